//--- verilog/uart_rx_aux_pkg.sv
// constants for the receive helper, interrupt and baud generator block
package uart_rx_aux_pkg;
  // register indices; byte address is four times the index
  localparam logic [2:0] IDX_DATA = 3'h0;
  localparam logic [2:0] IDX_IER = 3'h1;
  localparam logic [2:0] IDX_ISR = 3'h2;
  localparam logic [2:0] IDX_FCR = 3'h2; // write side of the status index
  localparam logic [2:0] IDX_LCR = 3'h3;
  localparam logic [2:0] IDX_MCR = 3'h4;
  localparam logic [2:0] IDX_LSR = 3'h5;
  localparam logic [2:0] IDX_MSR = 3'h6;
  localparam logic [2:0] IDX_SPR = 3'h7;
  localparam logic [2:0] IDX_DLL = 3'h0;
  localparam logic [2:0] IDX_DLM = 3'h1;
  localparam logic [2:0] IDX_EFR = 3'h2;
  localparam logic [2:0] IDX_XON1 = 3'h4;
  localparam logic [2:0] IDX_XON2 = 3'h5;
  localparam logic [2:0] IDX_XOFF1 = 3'h6;
  localparam logic [2:0] IDX_XOFF2 = 3'h7;
  localparam int ADDR_W = 12;
  localparam logic [7:0] LCR_KEY = 8'hBF;
  // field positions
  localparam int LCR_DLAB = 7;
  localparam int MCR_CLKSEL = 7;
  localparam int EFR_SPECIAL = 5;
  localparam int IER_THR = 1;
  localparam int IER_RX = 3;
  localparam int IER_SPECIAL = 5;
  localparam int IER_RTS = 6;
  localparam int IER_CTS = 7;
  localparam int FCR_ENABLE = 0;
  localparam int FCR_RXRST = 1;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_SPR = 8'hFF;
  // interrupt codes, bits 5:0 of status
  localparam logic [5:0] ISR_NONE = 6'h01;
  localparam logic [5:0] ISR_RXRDY = 6'h04;
  localparam logic [5:0] ISR_RXTO = 6'h0C;
  localparam logic [5:0] ISR_THRE = 6'h02;
  localparam logic [5:0] ISR_SPECIAL = 6'h10;
  localparam logic [5:0] ISR_FLOW = 6'h20;
  // time-out and baud constants
  localparam int TO_MULT = 4;
  localparam int TO_ADD = 12;
  localparam int WL_BASE = 5;
  localparam logic [3:0] BIT_TICKS_M1 = 4'hF;
  localparam logic [1:0] PRESCALE_M1 = 2'h3;
  localparam int FIFO_DEPTH = 16;
endpackage

//--- verilog/uart_rx_aux.sv
// receive helper, interrupt priority, time-out and baud generator with apb access
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module uart_rx_aux #(
  parameter int DEPTH = uart_rx_aux_pkg::FIFO_DEPTH
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uart_rx_aux_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // characters from the receive shifter, same clock
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_stop_mid,
  // transmitter side, same clock
  input wire logic tx_holding_empty,
  input wire logic tx_shift_empty,
  output logic tx_load,
  output logic [7:0] tx_data,
  // pins
  input wire logic osc_in,
  input wire logic cts_n,
  output logic baud_clock_out_n,
  output logic baud_tick,
  output logic int_out
);
  import uart_rx_aux_pkg::*;

  // pointer width; depth must be a power of two so the pointers wrap cleanly
  localparam int AW = $clog2(DEPTH);

  // all state of the block in one record: registers, fifo, counters, outputs
  // the fifo storage sits here too, so depth drives the flop count directly
  typedef struct packed {
    // software-visible registers
    logic [7:0] interrupt_enable_reg;
    logic [7:0] line_control_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] enhanced_feature_reg;
    logic [7:0] xon1;
    logic [7:0] xon2;
    logic [7:0] xoff1;
    logic [7:0] xoff2;
    logic [7:0] dll;
    logic [7:0] divisor_high_byte;
    logic [7:0] spr;
    logic [1:0] trig;
    logic fifo_en;
    // receive fifo storage and pointers
    logic [DEPTH-1:0][7:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    // sticky flags
    logic overrun;
    logic thr_int;
    logic thre_prev;
    logic spec_int;
    logic flow_int;
    // time-out: bit counter and baud ticks within a bit
    logic [6:0] to_cnt;
    logic [3:0] sub_cnt;
    logic to_int;
    // baud generator: prescaler and divisor counter
    logic [1:0] pre_cnt;
    logic [15:0] div_cnt;
    // two-stage synchronisers plus an edge history stage
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic cts_s1;
    logic cts_s2;
    logic cts_s3;
    // registered copies of every top-level output
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic int_out;
    logic baud_n;
    logic tick;
    logic tx_load;
    logic [7:0] tx_data;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [7:0] mask;
  logic [15:0] divisor;
  logic [AW:0] trig_lvl;
  logic [6:0] to_limit;
  logic [5:0] isr_code;
  logic [7:0] rd_val;
  logic [2:0] idx;
  logic mapped;
  logic setup;
  logic access;
  logic rd_rhr;
  logic pre_tick;
  logic div_tick;
  logic push;
  logic pop;
  logic to_restart;
  logic match;

  // word-length mask and time-out length from line control
  // trigger level decode sits here too; all three are pure decodes
  always_comb begin
    unique case (s_q.line_control_reg[1:0])
      2'b00: mask = 8'h1F;
      2'b01: mask = 8'h3F;
      2'b10: mask = 8'h7F;
      default: mask = 8'hFF;
    endcase
    to_limit = 7'(TO_MULT * (WL_BASE + int'(s_q.line_control_reg[1:0])) + TO_ADD);
    unique case (s_q.trig)
      2'b00: trig_lvl = (AW+1)'(1);
      2'b01: trig_lvl = (AW+1)'(4);
      2'b10: trig_lvl = (AW+1)'(8);
      default: trig_lvl = (AW+1)'(14);
    endcase
  end

  // divisor from high and low bytes
  // a divisor of zero stops the generator rather than dividing by 65536
  assign divisor = {s_q.divisor_high_byte, s_q.dll};

  // single highest pending source, flow lowest
  always_comb begin
    isr_code = ISR_NONE;
    // rx data and time-out under bit 3
    if (s_q.interrupt_enable_reg[IER_RX] && s_q.to_int) begin
      isr_code = ISR_RXTO;
    end else if (s_q.interrupt_enable_reg[IER_RX] && s_q.count >= trig_lvl) begin
      isr_code = ISR_RXRDY;
    end else if (s_q.interrupt_enable_reg[IER_THR] && s_q.thr_int) begin
      isr_code = ISR_THRE;
    end else if (s_q.interrupt_enable_reg[IER_SPECIAL] && s_q.spec_int) begin
      isr_code = ISR_SPECIAL;
    end else if ((s_q.interrupt_enable_reg[IER_CTS] || s_q.interrupt_enable_reg[IER_RTS]) && s_q.flow_int) begin
      isr_code = ISR_FLOW;
    end
  end

  // register read mux with bank selection
  always_comb begin
    // word index from the byte address; low bits must be zero
    idx = paddr[4:2];
    mapped = (paddr[ADDR_W-1:5] == '0) && (paddr[1:0] == 2'b00);
    rd_val = 8'h00;
    rd_rhr = 1'b0;
    // key value opens the feature bank
    if (s_q.line_control_reg == LCR_KEY && (idx == IDX_EFR || idx >= IDX_XON1)) begin
      unique case (idx)
        IDX_EFR: rd_val = s_q.enhanced_feature_reg;
        IDX_XON1: rd_val = s_q.xon1;
        IDX_XON2: rd_val = s_q.xon2;
        IDX_XOFF1: rd_val = s_q.xoff1;
        default: rd_val = s_q.xoff2;
      endcase
    // divisor bytes behind line bit 7
    end else if (s_q.line_control_reg[LCR_DLAB] && idx == IDX_DLL) begin
      rd_val = s_q.dll;
    end else if (s_q.line_control_reg[LCR_DLAB] && idx == IDX_DLM) begin
      rd_val = s_q.divisor_high_byte;
    end else begin
      unique case (idx)
        IDX_DATA: begin
          rd_val = s_q.mem[s_q.rptr];
          rd_rhr = 1'b1;
        end
        IDX_IER: rd_val = s_q.interrupt_enable_reg;
        IDX_ISR: rd_val = {{2{s_q.fifo_en}}, isr_code};
        IDX_LCR: rd_val = s_q.line_control_reg;
        IDX_MCR: rd_val = s_q.modem_control_reg;
        IDX_LSR: rd_val = {1'b0, tx_shift_empty, tx_holding_empty, 3'b000,
                           s_q.overrun, s_q.count != '0};
        IDX_MSR: rd_val = {3'b000, ~s_q.cts_s2, 4'h0};
        default: rd_val = s_q.spr;
      endcase
    end
  end

  // apb phases; access only counts once our own pready is up
  assign setup = psel && !penable;
  assign access = psel && penable && s_q.pready;
  // osc must stay well under half of pclk or synchronised edges are lost
  assign pre_tick = s_q.osc_s2 && !s_q.osc_s3 &&
                    (!s_q.modem_control_reg[MCR_CLKSEL] || s_q.pre_cnt == PRESCALE_M1);
  assign div_tick = pre_tick && divisor != 16'h0000 &&
                    s_q.div_cnt >= divisor - 16'h0001;
  // reading an empty holding register pops nothing but still restarts the time-out
  assign pop = access && !pwrite && mapped && rd_rhr && s_q.count != '0;
  assign push = rx_char_valid && s_q.count < (AW+1)'(DEPTH);
  // bit 0 aligned with first received bit, masked
  // bits above the programmed word length never take part in the compare
  assign match = ((rx_char_data ^ s_q.xoff2) & mask) == 8'h00;
  // restart at stop middle or holding read
  assign to_restart = rx_stop_mid || (access && !pwrite && mapped && rd_rhr);

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.tx_load = 1'b0;
    // apb answer: data captured in setup, pready in access
    // read data is frozen at setup, so a push in the access cycle cannot tear it
    s_d.pready = setup;
    if (setup) begin
      s_d.prdata = {24'h000000, mapped ? rd_val : 8'h00};
      s_d.pslverr = !mapped;
    end else begin
      s_d.pslverr = 1'b0;
    end
    // pin synchronisers
    s_d.osc_s1 = osc_in;
    s_d.osc_s2 = s_q.osc_s1;
    s_d.osc_s3 = s_q.osc_s2;
    s_d.cts_s1 = cts_n;
    s_d.cts_s2 = s_q.cts_s1;
    s_d.cts_s3 = s_q.cts_s2;
    // optional divide by four before divisor
    if (s_q.osc_s2 && !s_q.osc_s3) begin
      s_d.pre_cnt = s_q.modem_control_reg[MCR_CLKSEL] ? s_q.pre_cnt + 2'h1 : 2'h0;
    end
    // programmable divisor counter, osc edge counted
    // a divisor lowered below the count ends the period on the next prescaled osc edge
    if (div_tick) begin
      s_d.div_cnt = 16'h0000;
    end else if (pre_tick) begin
      s_d.div_cnt = s_q.div_cnt + 16'h0001;
    end
    // one low pulse per divisor period, shared tick
    s_d.baud_n = !div_tick;
    s_d.tick = div_tick;
    // bit period of sixteen baud ticks
    if (to_restart) begin
      s_d.sub_cnt = 4'h0;
      s_d.to_cnt = 7'h00;
      s_d.to_int = 1'b0;
    end else if (div_tick) begin
      s_d.sub_cnt = s_q.sub_cnt + 4'h1;
      if (s_q.sub_cnt == BIT_TICKS_M1 && s_q.to_cnt < to_limit) begin
        s_d.to_cnt = s_q.to_cnt + 7'h01;
      end
    end
    if (s_q.to_cnt >= to_limit && s_q.count != '0 && !to_restart) begin
      s_d.to_int = 1'b1;
    end
    if (push) begin
      s_d.mem[s_q.wptr] = rx_char_data;
      s_d.wptr = s_q.wptr + AW'(1);
    end
    if (pop) begin
      s_d.rptr = s_q.rptr + AW'(1);
    end
    s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop);
    // an emptied fifo can never hold a pending time-out
    if (s_d.count == '0) begin
      s_d.to_int = 1'b0;
    end
    // flow interrupt: rx fifo reaches trigger or cts released
    // register writes
    if (access && pwrite && mapped) begin
      if (s_q.line_control_reg == LCR_KEY && (idx == IDX_EFR || idx >= IDX_XON1)) begin
        unique case (idx)
          IDX_EFR: s_d.enhanced_feature_reg = pwdata[7:0];
          IDX_XON1: s_d.xon1 = pwdata[7:0];
          IDX_XON2: s_d.xon2 = pwdata[7:0];
          IDX_XOFF1: s_d.xoff1 = pwdata[7:0];
          default: s_d.xoff2 = pwdata[7:0];
        endcase
      end else if (s_q.line_control_reg[LCR_DLAB] && idx == IDX_DLL) begin
        s_d.dll = pwdata[7:0];
      end else if (s_q.line_control_reg[LCR_DLAB] && idx == IDX_DLM) begin
        s_d.divisor_high_byte = pwdata[7:0];
      end else begin
        unique case (idx)
          IDX_DATA: begin
            s_d.tx_load = 1'b1;
            s_d.tx_data = pwdata[7:0];
            s_d.thr_int = 1'b0;
          end
          IDX_IER: s_d.interrupt_enable_reg = pwdata[7:0];
          IDX_ISR: begin
            s_d.fifo_en = pwdata[FCR_ENABLE];
            s_d.trig = pwdata[7:6];
            // receive fifo reset wins over a push in the same cycle
            if (pwdata[FCR_RXRST]) begin
              s_d.wptr = '0;
              s_d.rptr = '0;
              s_d.count = '0;
              s_d.to_int = 1'b0;
            end
          end
          IDX_LCR: s_d.line_control_reg = pwdata[7:0];
          IDX_MCR: s_d.modem_control_reg = pwdata[7:0];
          IDX_SPR: s_d.spr = pwdata[7:0];
          default: ;
        endcase
      end
    end
    // status read side effects use the code captured in setup
    if (access && !pwrite && mapped && !s_q.line_control_reg[LCR_DLAB] && idx == IDX_ISR) begin
      unique case (s_q.prdata[5:0])
        ISR_THRE: s_d.thr_int = 1'b0;
        ISR_SPECIAL: s_d.spec_int = 1'b0;
        ISR_FLOW: s_d.flow_int = 1'b0;
        default: ;
      endcase
    end
    // overrun clears on a status read unless a new drop lands that cycle
    if (access && !pwrite && mapped && !s_q.line_control_reg[LCR_DLAB] && idx == IDX_LSR) begin
      s_d.overrun = 1'b0;
    end
    // event sets after clears so a coincident event wins
    if (rx_char_valid && !push) begin
      s_d.overrun = 1'b1;
    end
    // holding empty edge raises transmit interrupt
    // edge history for the holding-empty level
    s_d.thre_prev = tx_holding_empty;
    if (tx_holding_empty && !s_q.thre_prev) begin
      s_d.thr_int = 1'b1;
    end
    // enabled special match flagged, char already queued
    if (push && s_q.enhanced_feature_reg[EFR_SPECIAL] && match) begin
      s_d.spec_int = 1'b1;
    end
    // cts release or rts trigger reach
    if ((s_q.interrupt_enable_reg[IER_CTS] && s_q.cts_s2 && !s_q.cts_s3) ||
        (s_q.interrupt_enable_reg[IER_RTS] && push && s_q.count + (AW+1)'(1) == trig_lvl)) begin
      s_d.flow_int = 1'b1;
    end
    // pin follows the status code one cycle later
    s_d.int_out = isr_code != ISR_NONE;
  end

  // state register
  // transmit flag starts set with its history high, so no extra edge follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.spr <= RST_SPR;
      s_q.thr_int <= 1'b1;
      s_q.thre_prev <= 1'b1;
      s_q.baud_n <= 1'b1;
      s_q.osc_s1 <= 1'b0;
      s_q.cts_s1 <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign tx_load = s_q.tx_load;
  assign tx_data = s_q.tx_data;
  assign baud_clock_out_n = s_q.baud_n;
  assign baud_tick = s_q.tick;
  assign int_out = s_q.int_out;
endmodule

//--- test/uart_rx_aux_asserts.sv
// concurrent checks on the apb, transmit and baud ports
`timescale 1ns/1ps
module uart_rx_aux_asserts (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uart_rx_aux_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // outputs
  input wire logic tx_load,
  input wire logic baud_clock_out_n,
  input wire logic baud_tick
);
  import uart_rx_aux_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // setup phase, with an address above the map in the same cycle
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_bad;
    s_setup ##0 (paddr[11:5] != 7'h00);
  endsequence
  sequence s_good;
    s_setup ##0 (paddr[11:5] == 7'h00 && paddr[1:0] == 2'h0);
  endsequence
  a_ready_one: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  a_err_bad: assert property (s_bad |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_good: assert property (s_good |=> !pslverr)
    else $error("mapped access refused");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_rdata_hold: assert property (!psel |=> $stable(prdata))
    else $error("read data moved while idle");
  a_baud_pair: assert property (baud_tick != baud_clock_out_n)
    else $error("baud pin and tick disagree");
  // a 24 MHz osc sampled at 200 MHz can give rising edges only 8 cycles apart
  a_tick_gap: assert property (baud_tick |=> !baud_tick [*7])
    else $error("baud ticks closer than one osc period");
  a_load_cause: assert property (tx_load |->
    $past(psel && penable && pready && pwrite && paddr[4:2] == 3'h0) ##1 !tx_load)
    else $error("transmit load without data write");
endmodule
bind uart_rx_aux uart_rx_aux_asserts chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tx_load(tx_load), .baud_clock_out_n(baud_clock_out_n),
  .baud_tick(baud_tick));

//--- test/serial_peer.sv
// remote serial peer: free-running crystal and received characters
`timescale 1ns/1ps
module serial_peer (
  // block clock
  input wire logic pclk,
  // toward the block
  output logic osc_in,
  output logic rx_char_valid,
  output logic [7:0] rx_char_data,
  output logic rx_stop_mid
);
  // crystal near 22 MHz, under 24 MHz
  initial begin
    osc_in = 1'b0;
    rx_char_valid = 1'b0;
    rx_char_data = 8'h00;
    rx_stop_mid = 1'b0;
    #1.3;
    forever #22.5 osc_in = ~osc_in;
  end
  // bit 0 is the first bit on the line; stop middle comes with the char
  task automatic send(input logic [7:0] ch);
    @(posedge pclk);
    rx_char_data <= ch;
    rx_char_valid <= 1'b1;
    rx_stop_mid <= 1'b1;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    rx_stop_mid <= 1'b0;
    rx_char_data <= ~ch; // stale data is not held
  endtask
endmodule

//--- test/uart_rx_aux_tb.sv
// self-checking bench for the receive helper block
`timescale 1ns/1ps
module uart_rx_aux_tb;
  import uart_rx_aux_pkg::*;
  localparam int OSC = 9; // pclk cycles per osc period
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_load, int_out, cts_n;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, prd;
  logic rx_char_valid, rx_stop_mid, osc_in, baud_clock_out_n, baud_tick;
  logic [7:0] rx_char_data, tx_data;
  int fails, cmp_count, n;
  logic perr, thr_empty, shift_empty;
  uart_rx_aux uart_rx_aux_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_char_valid(rx_char_valid),
    .rx_char_data(rx_char_data), .rx_stop_mid(rx_stop_mid), .tx_holding_empty(thr_empty),
    .tx_shift_empty(shift_empty), .tx_load(tx_load), .tx_data(tx_data), .osc_in(osc_in),
    .cts_n(cts_n), .baud_clock_out_n(baud_clock_out_n), .baud_tick(baud_tick),
    .int_out(int_out));
  serial_peer serial_peer_i (.pclk(pclk), .osc_in(osc_in), .rx_char_valid(rx_char_valid),
    .rx_char_data(rx_char_data), .rx_stop_mid(rx_stop_mid));
  // clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    prd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    apb(1'b1, {7'h00, i, 2'h0}, d);
  endtask
  task automatic rd(input string nm, input logic [2:0] i, input logic [7:0] e);
    apb(1'b0, {7'h00, i, 2'h0}, 8'h00);
    chk(nm, prd, {24'h000000, e});
  endtask
  // pclk cycles between two baud ticks, second gap after a fresh tick
  task automatic gap(input string nm, input int e);
    do @(posedge pclk); while (baud_tick !== 1'b1);
    repeat (2) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (baud_tick !== 1'b1 && n < 9000);
    end
    chk(nm, n, e);
    chk({nm, "_pin"}, {31'h0, baud_clock_out_n}, 32'h0);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    stop_test();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, fails, cmp_count} = '0;
    presetn = 1'b0;
    cts_n = 1'b0;
    thr_empty = 1'b1;
    shift_empty = 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd("spr", IDX_SPR, RST_SPR);
    rd("isr", IDX_ISR, {2'h0, ISR_NONE});
    apb(1'b0, 12'h040, 8'h00);
    chk("err", prd, 32'h0);
    chk("err_flag", {31'h0, perr}, 32'h1);
    wr(IDX_IER, 8'h02);
    rd("isr", IDX_ISR, {2'h0, ISR_THRE});
    chk("int", {31'h0, int_out}, 32'h1);
    rd("isr", IDX_ISR, {2'h0, ISR_NONE});
    wr(IDX_IER, 8'h00);
    wr(IDX_DATA, 8'h5A);
    @(posedge pclk);
    chk("load", {31'h0, tx_load}, 32'h1);
    chk("txd", {24'h0, tx_data}, 32'h5A);
    thr_empty <= 1'b0;
    wr(IDX_IER, 8'h02);
    rd("isr", IDX_ISR, {2'h0, ISR_NONE});
    thr_empty <= 1'b1;
    @(posedge pclk);
    rd("isr", IDX_ISR, {2'h0, ISR_THRE});
    wr(IDX_IER, 8'h00);
    wr(IDX_LCR, 8'h80);
    wr(IDX_DLL, 8'h03);
    wr(IDX_DLM, 8'h00);
    rd("dll", IDX_DLL, 8'h03);
    gap("div3", 3 * OSC);
    wr(IDX_MCR, 8'h80);
    gap("pre4", 12 * OSC);
    wr(IDX_MCR, 8'h00);
    wr(IDX_DLM, 8'h01);
    wr(IDX_DLL, 8'h02);
    gap("div258", 258 * OSC);
    wr(IDX_DLL, 8'h01);
    wr(IDX_DLM, 8'h00);
    wr(IDX_LCR, 8'h00);
    rd("ier", IDX_IER, 8'h00);
    wr(IDX_LCR, LCR_KEY);
    wr(IDX_EFR, 8'h20);
    wr(IDX_XOFF2, 8'h1F);
    rd("xoff2", IDX_XOFF2, 8'h1F);
    wr(IDX_LCR, 8'h00);
    rd("spr", IDX_SPR, RST_SPR);
    wr(IDX_IER, 8'h20);
    serial_peer_i.send(8'hFF);
    rd("isr", IDX_ISR, {2'h0, ISR_SPECIAL});
    rd("isr", IDX_ISR, {2'h0, ISR_NONE});
    rd("rhr", IDX_DATA, 8'hFF);
    serial_peer_i.send(8'h1E);
    rd("isr", IDX_ISR, {2'h0, ISR_NONE});
    rd("rhr", IDX_DATA, 8'h1E);
    wr(IDX_FCR, 8'hC1);
    wr(IDX_IER, 8'h08);
    serial_peer_i.send(8'h33);
    repeat (4400) @(posedge pclk);
    rd("isr", IDX_ISR, 8'hC1);
    repeat (500) @(posedge pclk);
    rd("isr", IDX_ISR, {2'h3, ISR_RXTO});
    rd("rhr", IDX_DATA, 8'h33);
    rd("isr", IDX_ISR, 8'hC1);
    wr(IDX_FCR, 8'h01);
    wr(IDX_IER, 8'h88);
    serial_peer_i.send(8'h44);
    serial_peer_i.send(8'h45);
    rd("isr", IDX_ISR, {2'h3, ISR_RXRDY});
    cts_n <= 1'b1;
    repeat (4) @(posedge pclk);
    rd("isr", IDX_ISR, {2'h3, ISR_RXRDY});
    rd("rhr", IDX_DATA, 8'h44);
    shift_empty <= 1'b0;
    apb(1'b0, {7'h00, IDX_LSR, 2'h0}, 8'h00);
    chk("lsr0", prd, 32'h21);
    rd("rhr", IDX_DATA, 8'h45);
    rd("isr", IDX_ISR, {2'h3, ISR_FLOW});
    rd("isr", IDX_ISR, 8'hC1);
    stop_test();
  end
endmodule
